// *** design/rhda_top.sv ***
// Functional notes
// - No-protection bit disables overcurrent reporting
// - Overcurrent mode: collective or per-port reporting
// - Overcurrent mode resets equal to switch mode
// - Compound device bit always reads zero
// - No-power-switching keeps every port powered
// - Switch mode: ganged or individual port power
// - In individual mode, masked ports obey only per-port commands
// - Port count read-only, between 1 and 15
// - Second register holds per-port power mask
`timescale 1ns/1ps

module rhda_top
    import rhda_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    // Register bus
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic                  reg_wr_en,
    input  wire logic                  reg_rd_en,
    input  wire logic [3:0]            reg_be,
    input  wire logic [31:0]           reg_wdata,
    output logic      [31:0]           reg_rdata,
    output logic                       reg_rd_valid,
    // Power switch commands
    input  wire logic                  global_power_on_cmd,
    input  wire logic                  global_power_off_cmd,
    input  wire logic [NUM_PORTS:1]    port_power_on_cmd,
    input  wire logic [NUM_PORTS:1]    port_power_off_cmd,
    // Overcurrent pins and port status
    input  wire logic [NUM_PORTS:1]    overcurrent_pin,
    output logic      [NUM_PORTS:1]    port_power_reg,
    output logic      [NUM_PORTS:1]    port_overcurrent_reg,
    output logic                       global_overcurrent_reg
);

    // ==========================================================
    // Register state
    logic [7:0]           power_good_delay_reg;
    logic                 no_overcurrent_protect_reg;
    logic                 overcurrent_report_mode_reg;
    logic                 no_power_switching_reg;
    logic                 power_switch_mode_reg;
    logic [NUM_PORTS:1]   port_power_mask_reg;
    // Synchroniser stages and accepted state per pin
    logic [NUM_PORTS:1]   oc_meta_reg;
    logic [NUM_PORTS:1]   oc_sync2_reg;
    logic [NUM_PORTS:1]   oc_sync3_reg;
    logic [NUM_PORTS:1]   oc_state_reg;
    // Read images and write decode
    logic [31:0]          desc_a_value;
    logic [31:0]          desc_b_value;
    logic                 wr_desc_a;
    logic                 wr_desc_b;

    // ==========================================================
    // Write decode
    // Full offset match; writes to any other offset are dropped
    assign wr_desc_a = reg_wr_en && (reg_addr == ADDR_DESC_A);
    assign wr_desc_b = reg_wr_en && (reg_addr == ADDR_DESC_B);

    // ==========================================================
    // Read images
    // Reserved and unimplemented bits read as zero; built from
    // stored state so a read never waits on the write path
    always_comb begin
        desc_a_value = '0;
        desc_a_value[POS_PGD_LSB +: BYTE_W]      = power_good_delay_reg;
        desc_a_value[POS_NO_OC_PROT]             = no_overcurrent_protect_reg;
        desc_a_value[POS_OC_MODE]                = overcurrent_report_mode_reg;
        desc_a_value[POS_COMPOUND]               = COMPOUND_VALUE;
        desc_a_value[POS_NO_PWR_SW]              = no_power_switching_reg;
        desc_a_value[POS_PWR_SW_MODE]            = power_switch_mode_reg;
        desc_a_value[POS_PORT_CNT_LSB +: BYTE_W] = PORT_CNT_VALUE;
        desc_b_value = '0;
        desc_b_value[POS_MASK_LSB+1 +: NUM_PORTS] = port_power_mask_reg;
    end

    // ==========================================================
    // Descriptor register writes
    // Reserved bits are never stored, so a careless write cannot
    // leave them non-zero; device type and port count have no storage.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            power_good_delay_reg        <= RST_PGD;
            no_overcurrent_protect_reg  <= RST_NO_OC_PROT;
            overcurrent_report_mode_reg <= RST_OC_MODE;
            no_power_switching_reg      <= RST_NO_PWR_SW;
            power_switch_mode_reg       <= RST_PWR_SW_MODE;
        end else if (wr_desc_a) begin
            // Each lane is taken alone, so a partial write keeps the rest
            if (reg_be[LANE_PGD]) begin
                power_good_delay_reg <= reg_wdata[POS_PGD_LSB +: BYTE_W];
            end
            if (reg_be[LANE_MODE]) begin
                no_overcurrent_protect_reg  <= reg_wdata[POS_NO_OC_PROT];
                overcurrent_report_mode_reg <= reg_wdata[POS_OC_MODE];
                no_power_switching_reg      <= reg_wdata[POS_NO_PWR_SW];
                power_switch_mode_reg       <= reg_wdata[POS_PWR_SW_MODE];
            end
        end
    end

    // Port power mask, per-port bits only; bit 0 is reserved
    // The lane of each mask bit is worked out from its position, so
    // a wider port count needs no change here
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_power_mask_reg <= RST_MASK[NUM_PORTS:1];
        end else if (wr_desc_b) begin
            for (int i = 1; i <= NUM_PORTS; i++) begin
                if (reg_be[(POS_MASK_LSB + i) / BYTE_W]) begin
                    port_power_mask_reg[i] <= reg_wdata[POS_MASK_LSB + i];
                end
            end
        end
    end

    // ==========================================================
    // Read path: data one cycle after the read strobe
    // Valid is a one-cycle pulse that follows every read strobe
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
        end
    end

    // Read data holds between reads, so a slow master may take it late
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_rd_en) begin
            case (reg_addr)
                ADDR_DESC_A: reg_rdata <= desc_a_value;
                ADDR_DESC_B: reg_rdata <= desc_b_value;
                default:     reg_rdata <= '0;  // Unmapped reads zero
            endcase
        end
    end

    // ==========================================================
    // Port power control
    // Set and clear in the same cycle: switch-on wins, so a port is
    // never dropped by a racing pair of commands.
    // Leaving fixed power keeps ports on until a clear command, so a
    // mode change alone never drops a powered device.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_power_reg <= '0;
        end else begin
            for (int i = 1; i <= NUM_PORTS; i++) begin
                if (no_power_switching_reg) begin
                    port_power_reg[i] <= 1'b1;
                end else if (power_switch_mode_reg && port_power_mask_reg[i]) begin
                    if (port_power_on_cmd[i]) begin
                        port_power_reg[i] <= 1'b1;
                    end else if (port_power_off_cmd[i]) begin
                        port_power_reg[i] <= 1'b0;
                    end
                end else begin
                    if (global_power_on_cmd) begin
                        port_power_reg[i] <= 1'b1;
                    end else if (global_power_off_cmd) begin
                        port_power_reg[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Overcurrent pin synchroniser
    // Three stages; a change is taken only when stages two and three agree
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            oc_meta_reg  <= '0;
            oc_sync2_reg <= '0;
            oc_sync3_reg <= '0;
        end else begin
            oc_meta_reg  <= overcurrent_pin;
            oc_sync2_reg <= oc_meta_reg;
            oc_sync3_reg <= oc_sync2_reg;
        end
    end

    // Accepted state; a one-cycle glitch on a pin never reaches it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            oc_state_reg <= '0;
        end else begin
            for (int i = 1; i <= NUM_PORTS; i++) begin
                if (oc_sync2_reg[i] == oc_sync3_reg[i]) begin
                    oc_state_reg[i] <= oc_sync3_reg[i];
                end
            end
        end
    end

    // ==========================================================
    // Overcurrent reporting per the selected mode
    // Collective mode mirrors the OR on every port bit, so a driver
    // that polls a single port still sees the shared fault
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            port_overcurrent_reg   <= '0;
            global_overcurrent_reg <= 1'b0;
        end else if (no_overcurrent_protect_reg) begin
            port_overcurrent_reg   <= '0;
            global_overcurrent_reg <= 1'b0;
        end else if (overcurrent_report_mode_reg) begin
            port_overcurrent_reg   <= oc_state_reg;
            global_overcurrent_reg <= 1'b0;
        end else begin
            port_overcurrent_reg   <= {NUM_PORTS{|oc_state_reg}};
            global_overcurrent_reg <= |oc_state_reg;
        end
    end

endmodule

// *** design/rhda_pkg.sv ***
// ==========================================================
// Root hub descriptor constants
package rhda_pkg;
    // Number of root hub ports, fixed at build time (1 to 15)
    localparam int unsigned NUM_PORTS     = 2;
    localparam logic [7:0]  PORT_CNT_VALUE = 8'h02;
    // Width of the byte-wide fields and of one byte lane
    localparam int unsigned BYTE_W        = 8;

    // Register byte offsets from the base address
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  ADDR_DESC_A   = 8'h48;
    localparam logic [7:0]  ADDR_DESC_B   = 8'h4c;

    // Field positions in the first descriptor register
    localparam int unsigned POS_PGD_LSB   = 24;
    localparam int unsigned POS_NO_OC_PROT   = 12;
    localparam int unsigned POS_OC_MODE      = 11;
    localparam int unsigned POS_COMPOUND     = 10;
    localparam int unsigned POS_NO_PWR_SW    = 9;
    localparam int unsigned POS_PWR_SW_MODE  = 8;
    localparam int unsigned POS_PORT_CNT_LSB = 0;
    // Port power mask position in the second descriptor register
    localparam int unsigned POS_MASK_LSB  = 16;

    // Byte lanes holding the writable fields
    localparam int unsigned LANE_PGD      = 3;
    localparam int unsigned LANE_MODE     = 1;
    localparam int unsigned LANE_MASK_LO  = 2;
    localparam int unsigned LANE_MASK_HI  = 3;

    // Reset values
    localparam logic [7:0]  RST_PGD       = 8'hff;
    localparam logic        RST_NO_OC_PROT  = 1'b0;
    localparam logic        RST_PWR_SW_MODE = 1'b1;
    localparam logic        RST_OC_MODE     = RST_PWR_SW_MODE;
    localparam logic        RST_NO_PWR_SW   = 1'b0;
    localparam logic [15:0] RST_MASK        = 16'h0006;
    localparam logic        COMPOUND_VALUE  = 1'b0;

    // Power-good delay unit; software waits delay byte times this
    localparam int unsigned PGD_UNIT_MS   = 2;
endpackage

// *** test/rhda_assertions.sv ***
`timescale 1ns/1ps

module rhda_checker
    import rhda_pkg::*;
(
    input wire logic                  clk_sys,
    input wire logic                  sys_rst,
    input wire logic [ADDR_W-1:0]     reg_addr,
    input wire logic                  reg_wr_en,
    input wire logic                  reg_rd_en,
    input wire logic [3:0]            reg_be,
    input wire logic [31:0]           reg_wdata,
    input wire logic [31:0]           reg_rdata,
    input wire logic                  reg_rd_valid,
    input wire logic                  global_power_on_cmd,
    input wire logic                  global_power_off_cmd,
    input wire logic [NUM_PORTS:1]    port_power_on_cmd,
    input wire logic [NUM_PORTS:1]    port_power_off_cmd,
    input wire logic [NUM_PORTS:1]    overcurrent_pin,
    input wire logic [NUM_PORTS:1]    port_power_reg,
    input wire logic [NUM_PORTS:1]    port_overcurrent_reg,
    input wire logic                  global_overcurrent_reg
);
    logic [4:0] mode_q;
    logic [2:1] mask_q;
    logic [2:1] gsel;
    logic [2:1] oc_exp;
    // ==========================================
    // Shadow of mode bits and mask; compound flag bit kept at zero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mode_q <= {RST_NO_OC_PROT, RST_OC_MODE, COMPOUND_VALUE, RST_NO_PWR_SW, RST_PWR_SW_MODE};
            mask_q <= RST_MASK[2:1];
        end else begin
            if (reg_wr_en && reg_addr == ADDR_DESC_A && reg_be[1]) mode_q <= reg_wdata[12:8] & 5'h1b;
            if (reg_wr_en && reg_addr == ADDR_DESC_B && reg_be[2]) mask_q <= reg_wdata[18:17];
        end
    end
    // Ports under global control, and the overcurrent view expected
    assign gsel   = mode_q[0] ? ~mask_q : 2'h3;
    assign oc_exp = mode_q[4] ? 2'h0 : (mode_q[3] ? overcurrent_pin : {2{|overcurrent_pin}});
    // ==========================================
    // Properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Synchroniser needs several edges before outputs follow the pins
    sequence oc_settled;
        ($stable(overcurrent_pin) && $stable(mode_q))[*7];
    endsequence
    a_read_answer: assert property (reg_rd_en |=> reg_rd_valid) else $error("read not answered");
    a_compound_zero: assert property (reg_rd_en && reg_addr == ADDR_DESC_A |=>
        reg_rdata[POS_COMPOUND] == COMPOUND_VALUE) else $error("compound flag not zero");
    a_port_count: assert property (reg_rd_en && reg_addr == ADDR_DESC_A |=>
        reg_rdata[7:0] == PORT_CNT_VALUE) else $error("port count wrong");
    a_mode_readback: assert property (reg_rd_en && reg_addr == ADDR_DESC_A |=>
        reg_rdata[12:8] == $past(mode_q)) else $error("mode bits wrong");
    a_fixed_power: assert property (mode_q[1] |=> port_power_reg == 2'h3) else $error("ports not powered");
    a_global_on: assert property (!mode_q[1] && global_power_on_cmd |=>
        (port_power_reg & $past(gsel)) == $past(gsel)) else $error("global on missed");
    a_global_hold: assert property (!mode_q[1] && !global_power_on_cmd && !global_power_off_cmd |=>
        (port_power_reg & $past(gsel)) == ($past(port_power_reg) & $past(gsel))) else $error("global port moved");
    a_oc_ports: assert property (oc_settled |-> port_overcurrent_reg == oc_exp)
        else $error("port oc wrong");
    a_oc_global: assert property (oc_settled |->
        global_overcurrent_reg == (!mode_q[4] && !mode_q[3] && |overcurrent_pin)) else $error("global oc wrong");
endmodule

bind rhda_top rhda_checker rhda_checker_i (.clk_sys, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_be, .reg_wdata,
    .reg_rdata, .reg_rd_valid, .global_power_on_cmd, .global_power_off_cmd, .port_power_on_cmd, .port_power_off_cmd,
    .overcurrent_pin, .port_power_reg, .port_overcurrent_reg, .global_overcurrent_reg);

// *** test/root_hub_descriptor_a_bench.sv ***
`timescale 1ns/1ps

module root_hub_descriptor_a_bench;
    import rhda_pkg::*;
    logic        clk_sys = 1'h0, sys_rst = 1'h1, reg_wr_en = 1'h0, reg_rd_en = 1'h0, reg_rd_valid;
    logic        global_power_on_cmd = 1'h0, global_power_off_cmd = 1'h0, global_overcurrent_reg;
    logic [7:0]  reg_addr = 8'h0;
    logic [3:0]  reg_be = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [2:1]  port_power_on_cmd = 2'h0, port_power_off_cmd = 2'h0, overcurrent_pin = 2'h0;
    logic [2:1]  port_power_reg, port_overcurrent_reg;
    int          error_cnt = 0, comparisons = 0;
    rhda_top rhda_top_i (.clk_sys, .sys_rst, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_be, .reg_wdata, .reg_rdata,
        .reg_rd_valid, .global_power_on_cmd, .global_power_off_cmd, .port_power_on_cmd, .port_power_off_cmd,
        .overcurrent_pin, .port_power_reg, .port_overcurrent_reg, .global_overcurrent_reg);
    always #2 clk_sys = ~clk_sys;
    // ==========================================
    // Compare, bus and command tasks; inputs move on the falling edge
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge clk_sys);
        {reg_addr, reg_be, reg_wdata, reg_wr_en} = {a, be, d, 1'h1};
        @(negedge clk_sys);
        reg_wr_en = 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk_sys);
        {reg_addr, reg_rd_en} = {a, 1'h1};
        @(negedge clk_sys);
        chk("rd_valid", {31'h0, reg_rd_valid}, 32'h1);
        chk("rdata", reg_rdata, exp);
        reg_rd_en = 1'h0;
    endtask
    task cmd(input logic gon, input logic goff, input logic [2:1] pon, input logic [2:1] poff, input logic [2:1] exp);
        @(negedge clk_sys);
        {global_power_on_cmd, global_power_off_cmd, port_power_on_cmd, port_power_off_cmd} = {gon, goff, pon, poff};
        @(negedge clk_sys);
        {global_power_on_cmd, global_power_off_cmd, port_power_on_cmd, port_power_off_cmd} = 6'h0;
        chk("port_power_reg", {30'h0, port_power_reg}, {30'h0, exp});
    endtask
    // Generous settle wait, the pin path is several flops deep
    task oc(input logic [2:1] pin, input logic [2:1] ports, input logic glob);
        @(negedge clk_sys);
        overcurrent_pin = pin;
        repeat (8) @(negedge clk_sys);
        chk("port_overcurrent_reg", {30'h0, port_overcurrent_reg}, {30'h0, ports});
        chk("global_overcurrent_reg", {31'h0, global_overcurrent_reg}, {31'h0, glob});
    endtask
    task wrap_up;
        if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        sys_rst = 1'h0;
        rd(ADDR_DESC_A, 32'hff000902);
        rd(ADDR_DESC_B, 32'h00060000);
        rd(8'h50, 32'h0);
        wr(ADDR_DESC_A, 4'hf, 32'hff001fff);
        rd(ADDR_DESC_A, 32'hff001b02);
        cmd(1'h0, 1'h0, 2'h0, 2'h3, 2'h3);
        wr(ADDR_DESC_A, 4'hf, 32'h05000000);
        rd(ADDR_DESC_A, 32'h05000002);
        cmd(1'h0, 1'h1, 2'h0, 2'h0, 2'h0);
        cmd(1'h0, 1'h0, 2'h3, 2'h0, 2'h0);
        cmd(1'h1, 1'h0, 2'h0, 2'h0, 2'h3);
        wr(ADDR_DESC_A, 4'h2, 32'h00000100);
        cmd(1'h0, 1'h1, 2'h0, 2'h0, 2'h3);
        cmd(1'h0, 1'h0, 2'h0, 2'h1, 2'h2);
        wr(ADDR_DESC_B, 4'h4, 32'h00020000);
        rd(ADDR_DESC_B, 32'h00020000);
        cmd(1'h0, 1'h1, 2'h0, 2'h0, 2'h0);
        cmd(1'h0, 1'h0, 2'h3, 2'h0, 2'h1);
        cmd(1'h1, 1'h1, 2'h0, 2'h0, 2'h3);
        wr(ADDR_DESC_A, 4'h2, 32'h00000900);
        oc(2'h1, 2'h1, 1'h0);
        wr(ADDR_DESC_A, 4'h2, 32'h00000100);
        oc(2'h1, 2'h3, 1'h1);
        wr(ADDR_DESC_A, 4'h2, 32'h00001100);
        oc(2'h3, 2'h0, 1'h0);
        wrap_up();
    end
    // Run is well under 1000 cycles; cut a hang short
    initial begin
        #40000;
        error_cnt++;
        wrap_up();
    end
endmodule
